//--- verilog/pmrp_pkg.sv
package pmrp_pkg;

  // Bus and word widths
  localparam int unsigned APB_AW    = 12;
  localparam int unsigned APB_DW    = 32;
  localparam int unsigned REG_W     = 8;
  localparam int unsigned WORD_W    = 14;
  localparam int unsigned DATA_HI_W = WORD_W - REG_W;
  localparam int unsigned ADDR_HI_W = 4;
  localparam int unsigned MEM_AW    = 11;
  localparam int unsigned MEM_DEPTH = 2048;
  localparam int unsigned MEM_HI_W  = MEM_AW - REG_W;

  // Register indices; the byte address is four times the index
  localparam logic [APB_AW-1:0] IDX_DATA_LOW  = 12'h10C;
  localparam logic [APB_AW-1:0] IDX_ADDR_LOW  = 12'h10D;
  localparam logic [APB_AW-1:0] IDX_DATA_HIGH = 12'h10E;
  localparam logic [APB_AW-1:0] IDX_ADDR_HIGH = 12'h10F;
  localparam logic [APB_AW-1:0] IDX_CTRL      = 12'h18C;

  // Control register layout
  localparam int unsigned CTRL_START_BIT = 0;
  localparam logic [REG_W-1:0] CTRL_FIXED  = 8'h80;

  // Reset values
  localparam logic [REG_W-1:0]     RST_DATA_LOW  = 8'h00;
  localparam logic [DATA_HI_W-1:0] RST_DATA_HIGH = 6'h00;
  localparam logic [REG_W-1:0]     RST_ADDR_LOW  = 8'h00;
  localparam logic [ADDR_HI_W-1:0] RST_ADDR_HIGH = 4'h0;

  // Timing: instruction cycle is four clocks, a read takes two of them
  localparam int unsigned INSTR_DIV         = 4;
  localparam int unsigned READ_INSTR_CYCLES = 2;
  localparam logic [1:0]  DIV_LAST          = 2'(INSTR_DIV - 1);
  localparam logic [1:0]  READ_LAST_TICK    = 2'(READ_INSTR_CYCLES - 1);

  typedef enum logic {PMRP_IDLE, PMRP_READ} pmrp_state_t;

  function automatic logic [APB_AW-1:0] pmrp_byte_addr(input logic [APB_AW-1:0] idx);
    pmrp_byte_addr = {idx[APB_AW-3:0], 2'b00};
  endfunction

endpackage

//--- verilog/pmrp_mem.sv
`timescale 1ns/1ps
module pmrp_mem
(
  input  wire logic                             clk,
  input  wire logic                             rst_b,
  input  wire logic                             wr_en,
  input  wire logic [pmrp_pkg::MEM_AW-1:0]      wr_addr,
  input  wire logic [pmrp_pkg::WORD_W-1:0]      wr_data,
  input  wire logic [pmrp_pkg::MEM_AW-1:0]      rd_addr,
  output logic      [pmrp_pkg::WORD_W-1:0]      rd_data
);

  logic [pmrp_pkg::WORD_W-1:0] mem_array [pmrp_pkg::MEM_DEPTH];

  // Array is preloaded through the write port, standing in for OTP programming
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem_array[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rd_data <= '0;
    end
    else
    begin
      rd_data <= mem_array[rd_addr];
    end
  end

endmodule

//--- verilog/pmrp_top.sv
// The APB register port is this design's own decision.
`timescale 1ns/1ps
// Functional notes
// - Software reads program memory words through registers at any time, with no special mode.
// - The data high and data low registers together present one 14-bit program word.
// - Software writes a 12-bit word address into the address high and address low registers.
// - Address bits beyond the implemented 2K-word array are ignored.
// - Writing one to bit 0 of the control register launches one read of the addressed word.
// - The start bit is set-only from software; only hardware clears it.
// - A read completes after two instruction cycles and then the start bit is cleared.
// - On completion the data pair is loaded with the word at the held address.
// - Data high bits 5 to 0 hold word bits 13 to 8.
// - Data high bits 7 and 6 always read zero.
// - Control bit 7 reads one and control bits 6 to 1 read zero.
module pmrp_top
(
  input  wire logic                              clk,
  input  wire logic                              rst_b,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [pmrp_pkg::APB_AW-1:0]       paddr,
  input  wire logic [pmrp_pkg::APB_DW-1:0]       pwdata,
  output logic                                   pready,
  output logic      [pmrp_pkg::APB_DW-1:0]       prdata,
  output logic                                   pslverr,
  input  wire logic                              prog_wr_en,
  input  wire logic [pmrp_pkg::MEM_AW-1:0]       prog_wr_addr,
  input  wire logic [pmrp_pkg::WORD_W-1:0]       prog_wr_data
);

  logic [pmrp_pkg::REG_W-1:0]     data_lo_reg;
  logic [pmrp_pkg::DATA_HI_W-1:0] data_hi_reg;
  logic [pmrp_pkg::REG_W-1:0]     addr_lo_reg;
  logic [pmrp_pkg::ADDR_HI_W-1:0] addr_hi_reg;
  logic                           start_reg;
  logic                           start_next;
  pmrp_pkg::pmrp_state_t          state_reg;
  pmrp_pkg::pmrp_state_t          state_next;
  logic [1:0]                     div_cnt_reg;
  logic [1:0]                     tick_cnt_reg;
  logic                           pready_reg;
  logic [pmrp_pkg::APB_DW-1:0]    prdata_reg;
  logic                           pslverr_reg;
  logic [pmrp_pkg::WORD_W-1:0]    mem_rdata;

  wire                            tick;
  wire                            rd_done;
  wire                            launch;
  wire                            set_req;
  wire                            apb_acc;
  wire                            rd_sample;
  wire                            wr_commit;
  wire                            sel_data_lo;
  wire                            sel_data_hi;
  wire                            sel_addr_lo;
  wire                            sel_addr_hi;
  wire                            sel_ctrl;
  wire                            mapped;
  wire [pmrp_pkg::REG_W-1:0]      ctrl_val;
  wire [pmrp_pkg::REG_W-1:0]      rd_val;
  wire [pmrp_pkg::MEM_AW-1:0]     mem_addr;

  assign pready  = pready_reg;
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;

  // Address decode
  assign sel_data_lo = (paddr == pmrp_pkg::pmrp_byte_addr(pmrp_pkg::IDX_DATA_LOW));
  assign sel_data_hi = (paddr == pmrp_pkg::pmrp_byte_addr(pmrp_pkg::IDX_DATA_HIGH));
  assign sel_addr_lo = (paddr == pmrp_pkg::pmrp_byte_addr(pmrp_pkg::IDX_ADDR_LOW));
  assign sel_addr_hi = (paddr == pmrp_pkg::pmrp_byte_addr(pmrp_pkg::IDX_ADDR_HIGH));
  assign sel_ctrl    = (paddr == pmrp_pkg::pmrp_byte_addr(pmrp_pkg::IDX_CTRL));
  assign mapped      = sel_data_lo | sel_data_hi | sel_addr_lo | sel_addr_hi | sel_ctrl;

  // One wait state: pready rises in the second access cycle
  assign apb_acc   = psel & penable;
  assign rd_sample = apb_acc & ~pready_reg;
  assign wr_commit = apb_acc & pready_reg & pwrite & mapped;

  // Read mux
  assign ctrl_val = pmrp_pkg::CTRL_FIXED | {7'h00, start_reg};
  assign rd_val   = sel_data_lo ? data_lo_reg :
                    sel_data_hi ? {2'b00, data_hi_reg} :
                    sel_addr_lo ? addr_lo_reg :
                    sel_addr_hi ? {4'h0, addr_hi_reg} :
                    sel_ctrl    ? ctrl_val :
                    8'h00;

  // Read sequencing
  assign tick     = (div_cnt_reg == pmrp_pkg::DIV_LAST);
  assign set_req  = wr_commit & sel_ctrl & pwdata[pmrp_pkg::CTRL_START_BIT];
  assign rd_done  = (state_reg == pmrp_pkg::PMRP_READ) & tick
                    & (tick_cnt_reg == pmrp_pkg::READ_LAST_TICK);
  // A set landing on the completing cycle wins and starts the next read
  assign launch   = set_req & ((state_reg == pmrp_pkg::PMRP_IDLE) | rd_done);
  // Upper address bits fall away: the array has only 2K words
  assign mem_addr = {addr_hi_reg[pmrp_pkg::MEM_HI_W-1:0], addr_lo_reg};

  assign start_next = launch | (start_reg & ~rd_done);

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      pmrp_pkg::PMRP_IDLE:
      begin
        if (launch)
        begin
          state_next = pmrp_pkg::PMRP_READ;
        end
      end
      pmrp_pkg::PMRP_READ:
      begin
        if (rd_done && !launch)
        begin
          state_next = pmrp_pkg::PMRP_IDLE;
        end
      end
      default:
      begin
        state_next = pmrp_pkg::PMRP_IDLE;
      end
    endcase
  end

  // Instruction-cycle divider runs free, so read latency depends on phase
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      div_cnt_reg <= 2'h0;
    end
    else
    begin
      div_cnt_reg <= tick ? 2'h0 : 2'(div_cnt_reg + 2'h1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_reg    <= pmrp_pkg::PMRP_IDLE;
      start_reg    <= 1'b0;
      tick_cnt_reg <= 2'h0;
    end
    else
    begin
      state_reg <= state_next;
      start_reg <= start_next;
      if (launch)
      begin
        tick_cnt_reg <= 2'h0;
      end
      else if (state_reg == pmrp_pkg::PMRP_READ && tick)
      begin
        tick_cnt_reg <= 2'(tick_cnt_reg + 2'h1);
      end
    end
  end

  // Completion load beats a software write in the same cycle
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      data_lo_reg <= pmrp_pkg::RST_DATA_LOW;
      data_hi_reg <= pmrp_pkg::RST_DATA_HIGH;
    end
    else if (rd_done)
    begin
      data_lo_reg <= mem_rdata[pmrp_pkg::REG_W-1:0];
      data_hi_reg <= mem_rdata[pmrp_pkg::WORD_W-1:pmrp_pkg::REG_W];
    end
    else if (wr_commit)
    begin
      if (sel_data_lo)
      begin
        data_lo_reg <= pwdata[pmrp_pkg::REG_W-1:0];
      end
      if (sel_data_hi)
      begin
        data_hi_reg <= pwdata[pmrp_pkg::DATA_HI_W-1:0];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      addr_lo_reg <= pmrp_pkg::RST_ADDR_LOW;
      addr_hi_reg <= pmrp_pkg::RST_ADDR_HIGH;
    end
    else if (wr_commit)
    begin
      if (sel_addr_lo)
      begin
        addr_lo_reg <= pwdata[pmrp_pkg::REG_W-1:0];
      end
      if (sel_addr_hi)
      begin
        addr_hi_reg <= pwdata[pmrp_pkg::ADDR_HI_W-1:0];
      end
    end
  end

  // APB answer
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pready_reg  <= 1'b0;
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= rd_sample;
      if (rd_sample)
      begin
        prdata_reg  <= pwrite ? '0 : {24'h000000, rd_val};
        pslverr_reg <= ~mapped;
      end
      else
      begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  pmrp_mem u_mem
  (
    .clk     (clk),
    .rst_b   (rst_b),
    .wr_en   (prog_wr_en),
    .wr_addr (prog_wr_addr),
    .wr_data (prog_wr_data),
    .rd_addr (mem_addr),
    .rd_data (mem_rdata)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  apb_wait_one_a: assert property (rd_sample |=> pready_reg ##1 !pready_reg)
    else $error("pready not one cycle after first access cycle");

  start_launch_a: assert property (set_req && !start_reg |=> start_reg)
    else $error("start write did not set start bit");

  start_hold_a: assert property (start_reg && !rd_done |=> start_reg)
    else $error("start bit cleared before read done");

  read_min_a: assert property ($rose(start_reg) |-> start_reg[*5])
    else $error("read ended in under two instruction cycles");

  read_max_a: assert property ($rose(start_reg) |-> ##[4:7] rd_done)
    else $error("read did not finish in two instruction cycles");

  done_clear_a: assert property (rd_done && !set_req |=> !start_reg)
    else $error("start bit not cleared at read done");

  data_load_a: assert property (rd_done |=> {data_hi_reg, data_lo_reg} == $past(mem_rdata))
    else $error("data pair not loaded with array word");

  hi_zero_a: assert property (pready_reg && !pwrite && sel_data_hi |-> prdata_reg[7:6] == 2'b00)
    else $error("data high upper bits not zero");

  ctrl_fixed_a: assert property (pready_reg && !pwrite && sel_ctrl |-> prdata_reg[7:1] == 7'h40)
    else $error("control fixed bits wrong");

  busy_poll_a: assert property (rd_sample && !pwrite && sel_ctrl && start_reg |=> prdata_reg[0])
    else $error("start bit not visible while busy");

  addr_trim_a: assert property (mem_addr[pmrp_pkg::MEM_AW-1:pmrp_pkg::REG_W] == addr_hi_reg[2:0])
    else $error("array address not trimmed to implemented bits");

  unmapped_err_a: assert property (rd_sample && !mapped |=> pready_reg && pslverr_reg)
    else $error("unmapped access without pslverr");

  err_with_ready_a: assert property (pslverr_reg |-> pready_reg)
    else $error("pslverr without pready");

  write_rdata_zero_a: assert property (pready_reg && $past(pwrite) |-> prdata_reg == '0)
    else $error("write answer carried read data");

  prdata_upper_a: assert property (pready_reg |-> prdata_reg[31:8] == 24'h000000)
    else $error("upper read data bits not zero");

  busy_state_a: assert property (start_reg == (state_reg == pmrp_pkg::PMRP_READ))
    else $error("start bit disagrees with read state");

  div_period_a: assert property (tick |=> !tick [*3] ##1 tick)
    else $error("instruction cycle not four clocks");

  // Registers move only on a completion load or a bus write
  data_hold_a: assert property (!rd_done && !wr_commit |=> $stable({data_hi_reg, data_lo_reg}))
    else $error("data pair changed without load or write");

  addr_hold_a: assert property (!wr_commit |=> $stable({addr_hi_reg, addr_lo_reg}))
    else $error("address pair changed without write");

endmodule

//--- testbench/pmrp_preload.sv
`timescale 1ns/1ps
module pmrp_preload
(
  input  wire logic                        clk,
  output logic                             wr_en,
  output logic [pmrp_pkg::MEM_AW-1:0]      wr_addr,
  output logic [pmrp_pkg::WORD_W-1:0]      wr_data,
  output logic                             done
);
  logic [pmrp_pkg::MEM_AW:0] cnt_reg = '0;

  // Whole array is programmed once, then stays for reads at any time
  assign wr_en   = ~cnt_reg[pmrp_pkg::MEM_AW];
  assign wr_addr = cnt_reg[pmrp_pkg::MEM_AW-1:0];
  // Word differs at every address, so a stale or wrong fetch shows
  assign wr_data = {cnt_reg[2:0], cnt_reg[10:0]} ^ 14'h2C3A;
  assign done    = cnt_reg[pmrp_pkg::MEM_AW];

  always @(posedge clk)
  begin
    if (!done)
    begin
      cnt_reg <= cnt_reg + 12'h001;
    end
  end
endmodule

//--- testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        clk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        pl_en;
  logic [10:0] pl_addr;
  logic [13:0] pl_data;
  logic        pl_done;
  int          error_cnt;
  int          n_compared;
  logic [31:0] rd;
  logic        er;

  pmrp_top uut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .prog_wr_en(pl_en),
    .prog_wr_addr(pl_addr), .prog_wr_data(pl_data));
  pmrp_preload prt (.clk(clk), .wr_en(pl_en), .wr_addr(pl_addr), .wr_data(pl_data), .done(pl_done));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check8(input string name, input logic [7:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== {24'h000000, exp})
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check1(input string name, input logic exp, input logic got);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask

  // Byte address is four times the register index
  task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] wd);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx[9:0], 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      error_cnt++;
      $display("[ERR] pready expected 1 seen %b", pready);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [13:0] exp_word(input logic [10:0] a);
    exp_word = {a[2:0], a} ^ 14'h2C3A;
  endfunction

  task automatic prog_read(input logic [11:0] a);
    logic [13:0] w;
    int p;
    w = exp_word(a[10:0]);
    apb(1'b1, pmrp_pkg::IDX_ADDR_LOW, a[7:0]);
    apb(1'b1, pmrp_pkg::IDX_ADDR_HIGH, {4'h0, a[11:8]});
    apb(1'b1, pmrp_pkg::IDX_CTRL, 8'h01);
    apb(1'b0, pmrp_pkg::IDX_CTRL, 8'h00);
    check8("ctrl busy", 8'h81, rd);
    check1("ctrl busy err", 1'b0, er);
    apb(1'b1, pmrp_pkg::IDX_CTRL, 8'h00);
    p = 0;
    do
    begin
      apb(1'b0, pmrp_pkg::IDX_CTRL, 8'h00);
      p++;
    end
    while (rd[0] !== 1'b0 && p < 4);
    check8("ctrl done", 8'h80, rd);
    apb(1'b0, pmrp_pkg::IDX_DATA_LOW, 8'h00);
    check8("data low", w[7:0], rd);
    apb(1'b0, pmrp_pkg::IDX_DATA_HIGH, 8'h00);
    check8("data high", {2'b00, w[13:8]}, rd);
  endtask

  initial
  begin
    int n;
    error_cnt = 0;
    n_compared = 0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    n = 0;
    while (pl_done !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    if (pl_done !== 1'b1)
    begin
      error_cnt++;
      $display("[ERR] preload done expected 1 seen %b", pl_done);
    end
    apb(1'b0, pmrp_pkg::IDX_CTRL, 8'h00);
    check8("ctrl reset", 8'h80, rd);
    check1("ctrl reset err", 1'b0, er);
    apb(1'b0, pmrp_pkg::IDX_DATA_HIGH, 8'h00);
    check8("data high reset", 8'h00, rd);
    apb(1'b0, pmrp_pkg::IDX_ADDR_LOW, 8'h00);
    check8("addr low reset", 8'h00, rd);
    $display("test reset values done");
    apb(1'b1, pmrp_pkg::IDX_CTRL, 8'hFE);
    check8("write read data", 8'h00, rd);
    apb(1'b0, pmrp_pkg::IDX_CTRL, 8'h00);
    check8("ctrl fixed bits", 8'h80, rd);
    apb(1'b1, pmrp_pkg::IDX_DATA_HIGH, 8'hFF);
    apb(1'b0, pmrp_pkg::IDX_DATA_HIGH, 8'h00);
    check8("data high unused", 8'h3F, rd);
    apb(1'b1, pmrp_pkg::IDX_DATA_LOW, 8'hA5);
    apb(1'b0, pmrp_pkg::IDX_DATA_LOW, 8'h00);
    check8("data low write", 8'hA5, rd);
    apb(1'b1, pmrp_pkg::IDX_ADDR_HIGH, 8'hFF);
    apb(1'b0, pmrp_pkg::IDX_ADDR_HIGH, 8'h00);
    check8("addr high width", 8'h0F, rd);
    apb(1'b0, 12'h001, 8'h00);
    check1("unmapped err", 1'b1, er);
    check8("unmapped data", 8'h00, rd);
    apb(1'b1, 12'h001, 8'hFF);
    check1("unmapped write err", 1'b1, er);
    $display("test register access done");
    // Ends of the array, a mixed pattern, and an address with ignored upper bit
    prog_read(12'h000);
    prog_read(12'h7FF);
    prog_read(12'h555);
    prog_read(12'hABC);
    $display("test program reads done");
    test_done();
  end

  initial
  begin
    #200000;
    error_cnt++;
    $display("[ERR] watchdog expected finish seen hang");
    test_done();
  end
endmodule
